// *** common/usb_ctrl_pkg.sv ***
// Purpose: Shared constants, types and register map for the OUT endpoint and host pipe controller
// Assumes: One 200 MHz clock, word-aligned byte offsets on the plain register port
// Notes: Descriptor words live in flip-flops inside the controller
package usb_ctrl_pkg;
	localparam int NUM_BANKS = 2;
	localparam int NUM_PIPES = 4;
	localparam int BANK_W = 1;
	localparam int PIPE_W = 2;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 15;
	localparam int DEVADDR_W = 7;
	localparam int PCFG_W = 8;
	typedef logic [BANK_W-1:0] bank_t;
	typedef logic [CNT_W-1:0] count_t;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_EP_CFG = 8'h04;
	localparam logic [ADDR_W-1:0] REG_EP_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] REG_EP_CLR = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_HOST_STAT = 8'h10;
	localparam logic [ADDR_W-1:0] REG_HOST_CLR = 8'h14;
	localparam logic [ADDR_W-1:0] REG_PIPE_EN = 8'h18;
	localparam logic [ADDR_W-1:0] REG_PIPE0 = 8'h20;
	localparam logic [ADDR_W-1:0] REG_DESC0 = 8'h40;
	localparam logic [ADDR_W-1:0] PIPE_STRIDE = 8'h04;
	localparam logic [ADDR_W-1:0] DESC_STRIDE = 8'h08;
	localparam logic [ADDR_W-1:0] DESC_CTR_OFS = 8'h04;

	// Control register bits
	localparam int CTRL_EN = 0;
	localparam int CTRL_SOF_GENERATION_ENABLE = 1;
	localparam int CTRL_BUS_RESET = 2;
	localparam int CTRL_RECEIVED_OUT_IRQ_ENABLE = 3;
	localparam int CTRL_DFE = 4;
	localparam int CTRL_CRCE = 5;
	localparam int CTRL_ISO = 6;
	localparam int CTRL_MULTI_BANK = 7;
	// Endpoint clear bits (write one)
	localparam int CLR_RXOUT = 0;
	localparam int CLR_BANK = 1;
	localparam int CLR_DFERR = 2;
	localparam int CLR_CRC = 3;
	localparam int CLR_SOF = 4;
	// Host clear bits (write one)
	localparam int HCLR_RESET_SENT_FLAG = 0;
	localparam int HCLR_HWUP = 1;
	// Descriptor packet-size word
	localparam int PCK_BC_LSB = 0;
	localparam int PCK_MPS_LSB = 16;
	localparam int PCK_AUTO_ZLP = 31;
	// Descriptor control/status word
	localparam int CTR_DESCRIPTOR_CRC_ERROR = 16;
	localparam int CTR_OVERFLOW_STATUS = 17;
	localparam int CTR_UNDERFLOW_STATUS = 18;
	// Pipe register fields
	localparam int PIPE_CFG_LSB = 8;

	// Timing
	localparam int CLK_FREQ_KHZ = 200000;
	localparam int BUS_RESET_MS = 10;
	localparam int SOF_PERIOD_MS = 1;
	localparam logic [31:0] BUS_RESET_CYC = 32'(BUS_RESET_MS * CLK_FREQ_KHZ);
	localparam logic [31:0] SOF_PERIOD_CYC = 32'(SOF_PERIOD_MS * CLK_FREQ_KHZ);

	typedef enum logic [2:0] {HS_RESET, HS_IDLE, HS_READY, HS_SUSPEND, HS_RESUME, HS_BUS_RESET} host_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic done;
		logic crc_bad;
		count_t len;
	} out_pkt_t;
endpackage

// *** rtl/pcksize_update.sv ***
// Purpose: Byte-count update of one descriptor packet-size word after a received packet
// Assumes: Packet length never exceeds the endpoint size
// Notes: Pure combinational; a zero multi-packet size means single-packet mode
`timescale 1ns/1ps
`default_nettype none
module pcksize_update
	import usb_ctrl_pkg::*;
(
	input wire logic [31:0] word,
	input wire count_t len,
	input wire count_t eps,
	output logic [31:0] next_word,
	output logic bank_valid
);
	count_t bc;
	count_t mps;
	count_t sum;

	always_comb
	begin
		bc = word[PCK_BC_LSB +: CNT_W];
		mps = word[PCK_MPS_LSB +: CNT_W];
		sum = count_t'(bc + len);
		next_word = word;
		if (mps == '0)
		begin
			next_word[PCK_BC_LSB +: CNT_W] = len;
			bank_valid = 1'b1;
		end
		else
		begin
			next_word[PCK_BC_LSB +: CNT_W] = sum;
			bank_valid = (sum == mps) || (len < eps);
		end
	end
endmodule // pcksize_update
`default_nettype wire

// *** rtl/usb_out_host_ctrl.sv ***
// Purpose: OUT endpoint bank handshake, isochronous error reporting and host pipe control
// Assumes: Link-side packet events are single-cycle pulses synchronous to ref_clk
// Notes: A note on the address map and register port follows
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module usb_out_host_ctrl
	import usb_ctrl_pkg::*;
#(
	parameter logic [31:0] BUS_RESET_CYCLES = BUS_RESET_CYC,
	parameter logic [31:0] SOF_CYCLES = SOF_PERIOD_CYC
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire bus_req_t bus_req,
	input wire out_pkt_t out_pkt,
	input wire logic iso_in_empty_read,
	input wire bank_t iso_in_bank,
	input wire logic sof_rx,
	input wire logic sof_fnc_bad,
	input wire logic role_id,
	input wire logic dp_level,
	input wire logic dm_level,
	input wire logic tok_req,
	input wire logic [PIPE_W-1:0] tok_pipe,
	output logic [31:0] rdata,
	output logic endpoint_interrupt,
	output logic processing_irq,
	output logic exception_irq,
	output logic out_ack,
	output logic out_nak,
	output logic send_zlp,
	output logic bus_power_request,
	output logic bus_reset_drive,
	output logic sof_tx,
	output host_state_t host_state,
	output logic [DEVADDR_W-1:0] tok_addr,
	output logic tok_valid
);
	typedef struct packed {
		logic [31:0] rdata;
		logic [NUM_BANKS-1:0][31:0] pck;
		logic [NUM_BANKS-1:0][31:0] ctr;
		logic [NUM_BANKS-1:0] full;
		bank_t cur;
		bank_t wr_bank;
		logic received_out_flag;
		logic data_flow_error_flag;
		logic crc_error_flag;
		logic sof_flag;
		logic frame_number_crc_error;
		logic received_out_irq_enable;
		logic data_flow_error_enable;
		logic crc_error_enable;
		logic iso;
		logic multi_bank;
		count_t endpoint_packet_size;
		logic ep_irq;
		logic proc_irq;
		logic exc_irq;
		logic ack;
		logic nak;
		logic zlp;
		logic controller_enable;
		logic sof_generation_enable;
		host_state_t hs;
		logic [31:0] cnt;
		logic reset_sent_flag;
		logic host_wakeup_flag;
		logic sof_tx;
		logic bus_rst;
		logic bus_power_request;
		logic [NUM_PIPES-1:0] pipe_enable_reset_reg;
		logic [NUM_PIPES-1:0][DEVADDR_W-1:0] pipe_device_address;
		logic [NUM_PIPES-1:0][PCFG_W-1:0] pipe_cfg;
		logic [DEVADDR_W-1:0] tok_addr;
		logic tok_valid;
	} state_t;

	state_t s;
	state_t next_s;
	logic [31:0] upd_word;
	logic upd_valid;

	function automatic bank_t next_bank(input bank_t b, input logic multi);
		if (!multi)
			return b;
		return (b == bank_t'(NUM_BANKS - 1)) ? '0 : bank_t'(b + 1);
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
		input logic [ADDR_W-1:0] stride, input int idx);
		return a == ADDR_W'(base + stride * ADDR_W'(idx));
	endfunction

	function automatic logic [31:0] read_word(input state_t st, input logic [ADDR_W-1:0] a);
		logic [31:0] w;
		w = '0;
		if (a == REG_CTRL)
		begin
			w[CTRL_EN] = st.controller_enable;
			w[CTRL_SOF_GENERATION_ENABLE] = st.sof_generation_enable;
			w[CTRL_RECEIVED_OUT_IRQ_ENABLE] = st.received_out_irq_enable;
			w[CTRL_DFE] = st.data_flow_error_enable;
			w[CTRL_CRCE] = st.crc_error_enable;
			w[CTRL_ISO] = st.iso;
			w[CTRL_MULTI_BANK] = st.multi_bank;
		end
		if (a == REG_EP_CFG)
			w[CNT_W-1:0] = st.endpoint_packet_size;
		if (a == REG_EP_STAT)
		begin
			w[CLR_RXOUT] = st.received_out_flag;
			w[CLR_BANK] = st.full[st.cur];
			w[CLR_DFERR] = st.data_flow_error_flag;
			w[CLR_CRC] = st.crc_error_flag;
			w[CLR_SOF] = st.sof_flag;
			w[CLR_SOF+1] = st.frame_number_crc_error;
			w[PCK_MPS_LSB +: BANK_W] = st.cur;
		end
		if (a == REG_HOST_STAT)
		begin
			w[HCLR_RESET_SENT_FLAG] = st.reset_sent_flag;
			w[HCLR_HWUP] = st.host_wakeup_flag;
			w[HCLR_HWUP+1] = st.bus_power_request;
			w[PCK_MPS_LSB +: 3] = st.hs;
		end
		if (a == REG_PIPE_EN)
			w[NUM_PIPES-1:0] = st.pipe_enable_reset_reg;
		for (int p = 0; p < NUM_PIPES; p++)
			if (hit(a, REG_PIPE0, PIPE_STRIDE, p))
				w = {16'h0000, st.pipe_cfg[p], 1'b0, st.pipe_device_address[p]};
		for (int b = 0; b < NUM_BANKS; b++)
		begin
			if (hit(a, REG_DESC0, DESC_STRIDE, b))
				w = st.pck[b];
			if (hit(a, REG_DESC0 + DESC_CTR_OFS, DESC_STRIDE, b))
				w = st.ctr[b];
		end
		return w;
	endfunction

	pcksize_update u_pcksize (
		.word(s.pck[s.wr_bank]),
		.len(out_pkt.len),
		.eps(s.endpoint_packet_size),
		.next_word(upd_word),
		.bank_valid(upd_valid)
	);

	always_comb
	begin
		logic advance;
		logic fill;
		logic send_reset;
		logic connect;
		logic disconnect;
		bank_t b;
		advance = 1'b0;
		fill = 1'b0;
		send_reset = 1'b0;
		b = s.wr_bank;
		connect = dp_level || dm_level;
		disconnect = !dp_level && !dm_level;
		next_s = s;
		next_s.ack = 1'b0;
		next_s.nak = 1'b0;
		next_s.zlp = 1'b0;
		next_s.sof_tx = 1'b0;
		next_s.rdata = bus_req.rd ? read_word(s, bus_req.addr) : '0;

		// Software writes first so hardware events in the same cycle win
		if (bus_req.wr)
		begin
			if (bus_req.addr == REG_CTRL)
			begin
				next_s.controller_enable = bus_req.wdata[CTRL_EN];
				next_s.sof_generation_enable = bus_req.wdata[CTRL_SOF_GENERATION_ENABLE];
				next_s.received_out_irq_enable = bus_req.wdata[CTRL_RECEIVED_OUT_IRQ_ENABLE];
				next_s.data_flow_error_enable = bus_req.wdata[CTRL_DFE];
				next_s.crc_error_enable = bus_req.wdata[CTRL_CRCE];
				next_s.iso = bus_req.wdata[CTRL_ISO];
				next_s.multi_bank = bus_req.wdata[CTRL_MULTI_BANK];
				send_reset = bus_req.wdata[CTRL_BUS_RESET];
			end
			if (bus_req.addr == REG_EP_CFG)
				next_s.endpoint_packet_size = bus_req.wdata[CNT_W-1:0];
			if (bus_req.addr == REG_EP_CLR)
			begin
				if (bus_req.wdata[CLR_RXOUT])
					next_s.received_out_flag = 1'b0;
				advance = bus_req.wdata[CLR_BANK] && s.full[s.cur];
				if (bus_req.wdata[CLR_DFERR])
					next_s.data_flow_error_flag = 1'b0;
				if (bus_req.wdata[CLR_CRC])
					next_s.crc_error_flag = 1'b0;
				if (bus_req.wdata[CLR_SOF])
					next_s.sof_flag = 1'b0;
			end
			if (bus_req.addr == REG_HOST_CLR)
			begin
				if (bus_req.wdata[HCLR_RESET_SENT_FLAG])
					next_s.reset_sent_flag = 1'b0;
				if (bus_req.wdata[HCLR_HWUP])
					next_s.host_wakeup_flag = 1'b0;
			end
			if (bus_req.addr == REG_PIPE_EN)
				next_s.pipe_enable_reset_reg = bus_req.wdata[NUM_PIPES-1:0];
			for (int p = 0; p < NUM_PIPES; p++)
				if (hit(bus_req.addr, REG_PIPE0, PIPE_STRIDE, p))
				begin
					next_s.pipe_device_address[p] = bus_req.wdata[DEVADDR_W-1:0];
					next_s.pipe_cfg[p] = bus_req.wdata[PIPE_CFG_LSB +: PCFG_W];
				end
			for (int k = 0; k < NUM_BANKS; k++)
			begin
				if (hit(bus_req.addr, REG_DESC0, DESC_STRIDE, k))
					next_s.pck[k] = bus_req.wdata;
				if (hit(bus_req.addr, REG_DESC0 + DESC_CTR_OFS, DESC_STRIDE, k))
					next_s.ctr[k] = bus_req.wdata;
			end
		end

		// Bank release by firmware
		if (advance)
		begin
			next_s.full[s.cur] = 1'b0;
			next_s.cur = next_bank(s.cur, s.multi_bank);
		end

		// Received OUT packet into the filling bank
		if (out_pkt.done)
		begin
			if (next_s.full[b])
			begin
				next_s.nak = 1'b1;
				if (s.iso)
				begin
					next_s.data_flow_error_flag = 1'b1;
					next_s.ctr[b][CTR_OVERFLOW_STATUS] = 1'b1;
				end
			end
			else if (!out_pkt.crc_bad || s.iso)
			begin
				next_s.pck[b] = upd_word;
				next_s.ack = !out_pkt.crc_bad;
				if (!out_pkt.crc_bad && !next_s.data_flow_error_flag)
				begin
					next_s.ctr[b][CTR_OVERFLOW_STATUS] = 1'b0;
					next_s.ctr[b][CTR_UNDERFLOW_STATUS] = 1'b0;
				end
				if (out_pkt.crc_bad)
				begin
					next_s.crc_error_flag = 1'b1;
					next_s.ctr[b][CTR_DESCRIPTOR_CRC_ERROR] = 1'b1;
				end
				if (upd_valid || out_pkt.crc_bad)
				begin
					fill = 1'b1;
					next_s.full[b] = 1'b1;
					next_s.wr_bank = next_bank(b, s.multi_bank);
				end
			end
		end

		// Flag rises when the bank now current is full, by fill or by advance
		if ((fill && b == next_s.cur) || (advance && next_s.full[next_s.cur]))
			next_s.received_out_flag = 1'b1;

		// Empty isochronous IN bank read by the host
		if (iso_in_empty_read && s.iso)
		begin
			next_s.zlp = 1'b1;
			next_s.ctr[iso_in_bank][CTR_UNDERFLOW_STATUS] = 1'b1;
			next_s.data_flow_error_flag = 1'b1;
		end

		if (sof_rx)
		begin
			next_s.sof_flag = 1'b1;
			next_s.frame_number_crc_error = sof_fnc_bad;
		end

		// Host state machine; any exit from host operation drops back to Reset
		next_s.bus_power_request = s.controller_enable && !role_id;
		if (!s.controller_enable || role_id)
			next_s.hs = HS_RESET;
		else if (send_reset && s.hs != HS_BUS_RESET && s.hs != HS_RESUME)
		begin
			if (s.hs == HS_SUSPEND)
			begin
				next_s.hs = HS_RESUME;
				next_s.host_wakeup_flag = 1'b1;
				next_s.sof_generation_enable = 1'b1;
			end
			else
				next_s.hs = HS_BUS_RESET;
		end
		else
		begin
			unique case (s.hs)
				HS_RESET:
					next_s.hs = HS_IDLE;
				HS_IDLE:
					if (connect)
						next_s.hs = HS_READY;
				HS_READY:
				begin
					next_s.cnt = s.cnt + 32'h0000_0001;
					if (disconnect)
						next_s.hs = HS_IDLE;
					else if (!s.sof_generation_enable)
						next_s.hs = HS_SUSPEND;
					else if (s.cnt >= SOF_CYCLES - 32'h0000_0001)
					begin
						next_s.sof_tx = 1'b1;
						next_s.cnt = '0;
					end
				end
				HS_SUSPEND:
					if (disconnect)
						next_s.hs = HS_IDLE;
					else if (s.sof_generation_enable)
						next_s.hs = HS_READY;
				HS_RESUME:
					next_s.hs = HS_BUS_RESET;
				HS_BUS_RESET:
				begin
					// Line levels are ignored while the reset is driven
					next_s.cnt = s.cnt + 32'h0000_0001;
					if (s.cnt >= BUS_RESET_CYCLES - 32'h0000_0001)
					begin
						next_s.reset_sent_flag = 1'b1;
						next_s.pipe_enable_reset_reg = '0;
						next_s.hs = HS_READY;
					end
				end
			endcase
		end
		if (next_s.hs != s.hs)
			next_s.cnt = '0;
		next_s.bus_rst = next_s.hs == HS_BUS_RESET;

		for (int p = 0; p < NUM_PIPES; p++)
			if (!next_s.pipe_enable_reset_reg[p])
				next_s.pipe_cfg[p] = '0;

		// Token issue uses the live pipe-register device address of an enabled pipe
		next_s.tok_valid = tok_req && next_s.pipe_enable_reset_reg[tok_pipe] && s.hs == HS_READY;
		if (tok_req)
			next_s.tok_addr = next_s.pipe_device_address[tok_pipe];

		next_s.ep_irq = (next_s.received_out_flag && next_s.received_out_irq_enable)
			|| (next_s.data_flow_error_flag && next_s.data_flow_error_enable)
			|| (next_s.crc_error_flag && next_s.crc_error_enable);
		next_s.proc_irq = (next_s.sof_flag && !next_s.frame_number_crc_error)
			|| (next_s.received_out_flag && next_s.received_out_irq_enable);
		next_s.exc_irq = (next_s.sof_flag && next_s.frame_number_crc_error)
			|| (next_s.data_flow_error_flag && next_s.data_flow_error_enable)
			|| (next_s.crc_error_flag && next_s.crc_error_enable);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

	assign rdata = s.rdata;
	assign endpoint_interrupt = s.ep_irq;
	assign processing_irq = s.proc_irq;
	assign exception_irq = s.exc_irq;
	assign out_ack = s.ack;
	assign out_nak = s.nak;
	assign send_zlp = s.zlp;
	assign bus_power_request = s.bus_power_request;
	assign bus_reset_drive = s.bus_rst;
	assign sof_tx = s.sof_tx;
	assign host_state = s.hs;
	assign tok_addr = s.tok_addr;
	assign tok_valid = s.tok_valid;
endmodule // usb_out_host_ctrl
`default_nettype wire

// *** bench/usb_out_host_ctrl_monitor.sv ***
// Purpose: Port-level checks of the OUT endpoint and host pipe controller
// Assumes: Bound to every instance of the controller; ce may be held high
// Notes: Bus reset length is counted in helper logic, not unrolled
`timescale 1ns/1ps
`default_nettype none
module usb_out_host_ctrl_monitor
	import usb_ctrl_pkg::*;
#(
	parameter logic [31:0] BUS_RESET_CYCLES = BUS_RESET_CYC
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire bus_req_t bus_req,
	input wire out_pkt_t out_pkt,
	input wire logic iso_in_empty_read,
	input wire logic dp_level,
	input wire logic dm_level,
	input wire logic tok_req,
	input wire logic [31:0] rdata,
	input wire logic out_ack,
	input wire logic out_nak,
	input wire logic send_zlp,
	input wire logic bus_power_request,
	input wire logic sof_tx,
	input wire host_state_t host_state,
	input wire logic tok_valid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] rst_len;
	logic [31:0] next_rst_len;
	always_comb
	begin
		next_rst_len = (host_state == HS_BUS_RESET) ? rst_len + 32'h1 : 32'h0;
	end
	// Frozen while ce is low, like the design
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_len <= 32'h0;
		else if (ce)
			rst_len <= next_rst_len;
	end
	sequence pkt_good;
		ce && out_pkt.done && !out_pkt.crc_bad;
	endsequence
	sequence enter_bus_reset;
		$rose(host_state == HS_BUS_RESET);
	endsequence
	chk_pkt_answered: assert property (pkt_good |=> out_ack != out_nak)
		else $error("good packet got no single answer");
	chk_answer_cause: assert property ((out_ack || out_nak) |-> $past(out_pkt.done))
		else $error("answer without packet");
	chk_rdata_idle: assert property ($past(ce && !bus_req.rd) |-> rdata == 32'h0)
		else $error("read data outside read slot");
	chk_sof_ready: assert property (sof_tx |-> host_state == HS_READY || $past(host_state) == HS_READY)
		else $error("frame start outside ready");
	chk_power_ready: assert property (host_state == HS_READY |-> bus_power_request)
		else $error("no bus power while ready");
	chk_reset_length: assert property (rst_len <= BUS_RESET_CYCLES + 32'h2)
		else $error("bus reset overran");
	chk_reset_hold: assert property (enter_bus_reset |-> (host_state == HS_BUS_RESET)[*8])
		else $error("bus reset cut short");
	chk_token_ready: assert property (tok_valid |-> $past(tok_req) && $past(host_state) == HS_READY)
		else $error("token outside ready or unrequested");
	chk_zlp_cause: assert property (send_zlp |-> $past(iso_in_empty_read))
		else $error("zero-length packet without empty read");
	chk_detach_seen: assert property (ce && host_state == HS_READY && !dp_level && !dm_level
		|=> host_state != HS_READY)
		else $error("detach not seen");
endmodule // usb_out_host_ctrl_monitor
bind usb_out_host_ctrl usb_out_host_ctrl_monitor #(.BUS_RESET_CYCLES(BUS_RESET_CYCLES)) i_mon (
	.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .out_pkt(out_pkt),
	.iso_in_empty_read(iso_in_empty_read), .dp_level(dp_level), .dm_level(dm_level), .tok_req(tok_req),
	.rdata(rdata), .out_ack(out_ack), .out_nak(out_nak), .send_zlp(send_zlp),
	.bus_power_request(bus_power_request), .sof_tx(sof_tx), .host_state(host_state), .tok_valid(tok_valid)
);
`default_nettype wire

// *** bench/usb_far_end_model.sv ***
// Purpose: Far side of the link: packets, frame starts, empty reads and line levels
// Assumes: Events are one-cycle pulses on ref_clk
// Notes: Length lines carry a changing pattern outside a packet
`timescale 1ns/1ps
`default_nettype none
module usb_far_end_model
	import usb_ctrl_pkg::*;
(
	input wire logic ref_clk,
	output var out_pkt_t out_pkt,
	output logic iso_in_empty_read,
	output var bank_t iso_in_bank,
	output logic sof_rx,
	output logic sof_fnc_bad,
	output logic dp_level,
	output logic dm_level
);
	initial
	begin
		out_pkt = '0;
		iso_in_empty_read = 1'b0;
		iso_in_bank = '0;
		sof_rx = 1'b0;
		sof_fnc_bad = 1'b0;
		dp_level = 1'b0;
		dm_level = 1'b0;
	end
	// Sends even into a full bank, as a real host does
	task automatic pkt(input count_t len, input logic bad);
		@(posedge ref_clk);
		out_pkt <= '{done: 1'b1, crc_bad: bad, len: len};
		@(posedge ref_clk);
		out_pkt <= '{done: 1'b0, crc_bad: 1'($urandom), len: count_t'($urandom)};
	endtask
	task automatic empty_rd(input bank_t b);
		@(posedge ref_clk);
		iso_in_empty_read <= 1'b1;
		iso_in_bank <= b;
		@(posedge ref_clk);
		iso_in_empty_read <= 1'b0;
		iso_in_bank <= ~b;
	endtask
	task automatic sof(input logic bad);
		@(posedge ref_clk);
		sof_rx <= 1'b1;
		sof_fnc_bad <= bad;
		@(posedge ref_clk);
		sof_rx <= 1'b0;
		sof_fnc_bad <= ~bad;
	endtask
	task automatic line(input logic dp, input logic dm);
		@(posedge ref_clk);
		dp_level <= dp;
		dm_level <= dm;
	endtask
endmodule // usb_far_end_model
`default_nettype wire

// *** bench/usb_out_endpoint_and_host_pipe_control_test.sv ***
// Purpose: Self-checking bench for the OUT endpoint and host pipe controller
// Assumes: Shortened bus reset and frame periods
// Notes: Register reads and tokens are noted in queues and checked by a watcher
`timescale 1ns/1ps
`default_nettype none
module usb_out_endpoint_and_host_pipe_control_test import usb_ctrl_pkg::*;;
	typedef struct {logic [7:0] a; logic [31:0] e;} note_t;
	note_t rq[$];
	logic [6:0] tq[$];
	int miscompares, num_checks, cyc;
	logic pend, ref_clk, rst_n, role_id, tok_req, ce;
	bus_req_t bus_req;
	out_pkt_t out_pkt;
	logic iso_in_empty_read, sof_rx, sof_fnc_bad, dp_level, dm_level, sof_tx, tok_valid;
	bank_t iso_in_bank;
	logic [PIPE_W-1:0] tok_pipe;
	logic [31:0] rdata;
	logic endpoint_interrupt, processing_irq, exception_irq, out_ack, out_nak, send_zlp, bus_power_request;
	logic bus_reset_drive;
	host_state_t host_state;
	logic [DEVADDR_W-1:0] tok_addr, a7;
	count_t l1, l2;
	usb_far_end_model i_far (.ref_clk(ref_clk), .out_pkt(out_pkt), .iso_in_empty_read(iso_in_empty_read),
		.iso_in_bank(iso_in_bank), .sof_rx(sof_rx), .sof_fnc_bad(sof_fnc_bad), .dp_level(dp_level),
		.dm_level(dm_level));
	usb_out_host_ctrl #(.BUS_RESET_CYCLES(32'h14), .SOF_CYCLES(32'h10)) i_dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .ce(ce), .bus_req(bus_req), .out_pkt(out_pkt), .iso_in_empty_read(iso_in_empty_read),
		.iso_in_bank(iso_in_bank), .sof_rx(sof_rx), .sof_fnc_bad(sof_fnc_bad), .role_id(role_id),
		.dp_level(dp_level), .dm_level(dm_level), .tok_req(tok_req), .tok_pipe(tok_pipe), .rdata(rdata),
		.endpoint_interrupt(endpoint_interrupt), .processing_irq(processing_irq), .exception_irq(exception_irq),
		.out_ack(out_ack), .out_nak(out_nak), .send_zlp(send_zlp), .bus_power_request(bus_power_request),
		.bus_reset_drive(bus_reset_drive), .sof_tx(sof_tx), .host_state(host_state), .tok_addr(tok_addr),
		.tok_valid(tok_valid));
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic reset(input logic r);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		role_id <= r;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		rq.push_back('{a: a, e: e});
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
	endtask
	task automatic tok(input logic [PIPE_W-1:0] p, input logic en, input logic [6:0] a);
		@(posedge ref_clk);
		tok_req <= 1'b1;
		tok_pipe <= p;
		if (en)
			tq.push_back(a);
		@(posedge ref_clk);
		tok_req <= 1'b0;
	endtask
	// Bounded wait; a hang shows as a state mismatch
	task automatic wait_state(input host_state_t s);
		repeat (100)
		begin
			@(negedge ref_clk);
			if (host_state === s)
				break;
		end
		chk("host_state", 32'(s), 32'(host_state));
	endtask
	always @(posedge ref_clk)
		pend <= bus_req.rd;
	always @(negedge ref_clk)
	begin
		if (pend && rq.size() > 0)
			chk($sformatf("reg_%h", rq[0].a), rq[0].e, rdata);
		if (pend && rq.size() > 0)
			void'(rq.pop_front());
		if (tok_valid && tq.size() == 0)
			chk("tok_valid", 32'h0, 32'h1);
		else if (tok_valid)
			chk("tok_addr", 32'(tq.pop_front()), 32'(tok_addr));
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end
	initial
	begin
		rst_n = 1'b0;
		role_id = 1'b1;
		tok_req = 1'b0;
		ce = 1'b1;
		tok_pipe = '0;
		bus_req = '0;
		pend = 1'b0;
		void'($urandom(43));
		reset(1'b1);
		rd(REG_EP_STAT, 32'h0);
		rd(REG_HOST_STAT, 32'h0);
		wr(8'hFC, 32'hFFFF_FFFF);
		rd(8'hFC, 32'h0);
		l1 = count_t'(1 + $urandom % 63);
		l2 = count_t'(1 + $urandom % 63);
		wr(REG_EP_CFG, 32'h40);
		wr(REG_CTRL, 32'h89);
		i_far.pkt(l1, 1'b0);
		@(negedge ref_clk);
		chk("endpoint_interrupt", 32'h1, 32'(endpoint_interrupt));
		rd(REG_EP_STAT, 32'h3);
		i_far.pkt(l2, 1'b0);
		rd(REG_DESC0, 32'(l1));
		rd(REG_DESC0 + DESC_STRIDE, 32'(l2));
		wr(REG_EP_CLR, 32'h1);
		rd(REG_EP_STAT, 32'h2);
		rd(REG_DESC0, 32'(l1));
		wr(REG_EP_CLR, 32'h2);
		rd(REG_EP_STAT, 32'h0001_0003);
		reset(1'b1);
		wr(REG_EP_CFG, 32'h40);
		wr(REG_CTRL, 32'h1);
		wr(REG_DESC0, 32'h0080_0000);
		i_far.pkt(15'h40, 1'b0);
		rd(REG_EP_STAT, 32'h0);
		rd(REG_DESC0, 32'h0080_0040);
		i_far.pkt(15'h40, 1'b0);
		rd(REG_EP_STAT, 32'h3);
		rd(REG_DESC0, 32'h0080_0080);
		reset(1'b1);
		wr(REG_EP_CFG, 32'h40);
		wr(REG_CTRL, 32'h71);
		i_far.pkt(15'h8, 1'b0);
		@(negedge ref_clk);
		chk("endpoint_interrupt", 32'h0, 32'(endpoint_interrupt));
		i_far.pkt(15'h8, 1'b0);
		@(negedge ref_clk);
		chk("endpoint_interrupt", 32'h1, 32'(endpoint_interrupt));
		rd(REG_EP_STAT, 32'h7);
		rd(REG_DESC0 + DESC_CTR_OFS, 32'h0002_0000);
		wr(REG_EP_CLR, 32'h7);
		i_far.pkt(15'h8, 1'b0);
		rd(REG_DESC0 + DESC_CTR_OFS, 32'h0);
		wr(REG_EP_CLR, 32'h3);
		i_far.pkt(15'h8, 1'b1);
		rd(REG_EP_STAT, 32'hB);
		rd(REG_DESC0 + DESC_CTR_OFS, 32'h0001_0000);
		i_far.empty_rd(1'b1);
		rd(REG_DESC0 + DESC_STRIDE + DESC_CTR_OFS, 32'h0004_0000);
		wr(REG_EP_CLR, 32'h1F);
		i_far.sof(1'b1);
		@(negedge ref_clk);
		chk("exception_irq", 32'h1, 32'(exception_irq));
		chk("processing_irq", 32'h0, 32'(processing_irq));
		rd(REG_EP_STAT, 32'h30);
		wr(REG_EP_CLR, 32'h10);
		i_far.sof(1'b0);
		@(negedge ref_clk);
		chk("processing_irq", 32'h1, 32'(processing_irq));
		chk("exception_irq", 32'h0, 32'(exception_irq));
		rd(REG_EP_STAT, 32'h10);
		reset(1'b0);
		wr(REG_CTRL, 32'h3);
		wait_state(HS_IDLE);
		rd(REG_HOST_STAT, 32'h0001_0004);
		i_far.line(1'b1, 1'b0);
		wait_state(HS_READY);
		a7 = 7'($urandom);
		wr(REG_PIPE_EN, 32'h1);
		wr(REG_PIPE0, {16'h0, 8'h5A, 1'b0, a7});
		rd(REG_PIPE0, {16'h0, 8'h5A, 1'b0, a7});
		wr(REG_PIPE0 + PIPE_STRIDE, 32'h5A01);
		rd(REG_PIPE0 + PIPE_STRIDE, 32'h01);
		tok(2'h0, 1'b1, a7);
		tok(2'h1, 1'b0, 7'h0);
		wr(REG_CTRL, 32'h7);
		wait_state(HS_BUS_RESET);
		// Freeze longer than the whole reset: a free-running count would reach Ready
		@(posedge ref_clk);
		ce <= 1'b0;
		repeat (24 + $urandom % 8) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("frozen_state", 32'(HS_BUS_RESET), 32'(host_state));
		chk("bus_reset_drive", 32'h1, 32'(bus_reset_drive));
		@(posedge ref_clk);
		ce <= 1'b1;
		wait_state(HS_READY);
		chk("bus_reset_drive", 32'h0, 32'(bus_reset_drive));
		rd(REG_HOST_STAT, 32'h0002_0005);
		rd(REG_PIPE_EN, 32'h0);
		wr(REG_HOST_CLR, 32'h1);
		wr(REG_CTRL, 32'h1);
		wait_state(HS_SUSPEND);
		wr(REG_CTRL, 32'h5);
		wait_state(HS_READY);
		rd(REG_HOST_STAT, 32'h0002_0007);
		rd(REG_CTRL, 32'h3);
		i_far.line(1'b0, 1'b0);
		wait_state(HS_IDLE);
		repeat (4) @(posedge ref_clk);
		chk("tok_left", 32'h0, 32'(tq.size()));
		chk("reads_left", 32'h0, 32'(rq.size()));
		finish_test();
	end
endmodule // usb_out_endpoint_and_host_pipe_control_test
`default_nettype wire
